// [ppo_pkg.sv]
// Purpose: Shared constants for the port B alternate-function override logic.
// Assumes: Eight pins per port and 32-bit APB data.
// Notes:   Register offsets are byte addresses of aligned words.
`default_nettype none
package ppo_pkg;
  localparam int unsigned NPINS       = 8;
  localparam int unsigned ADDR_LSB_W  = 8;
  // Register byte offsets.
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  OUT_OFS     = 8'h04;
  localparam logic [7:0]  DIR_OFS     = 8'h08;
  localparam logic [7:0]  PIN_OFS     = 8'h0C;
  localparam logic [7:0]  PADST_OFS   = 8'h10;
  // Field positions and reset values.
  localparam int unsigned PUD_BIT     = 4;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  OUT_RST     = 8'h00;
  localparam logic [7:0]  DIR_RST     = 8'h00;
  // Pull-up on when {direction, output, pull-up disable} takes this value.
  localparam logic [2:0]  PU_PATTERN  = 3'b010;
  // Port B pin positions of the alternate functions.
  localparam int unsigned PIN_SS      = 0;
  localparam int unsigned PIN_SCK     = 1;
  localparam int unsigned PIN_MOSI    = 2;
  localparam int unsigned PIN_MISO    = 3;
  localparam int unsigned PIN_T1A     = 5;
  localparam int unsigned PIN_T1B     = 6;
  localparam int unsigned PIN_T7      = 7;
endpackage
`default_nettype wire

// [ppo_if.sv]
// Purpose: Override carrier between the port pin logic and the peripherals.
// Assumes: One bit per pin in every vector.
// Notes:   No clocking block; both ends run on pclk.
`default_nettype none
interface ppo_if;
  logic [7:0] pullup_override_en;
  logic [7:0] pullup_override_val;
  logic [7:0] dir_override_en;
  logic [7:0] dir_override_val;
  logic [7:0] value_override_en;
  logic [7:0] value_override_val;
  logic [7:0] toggle_override_en;
  logic [7:0] input_en_override_en;
  logic [7:0] input_en_override_val;
  logic [7:0] alt_digital_input_tap;
  logic [7:0] analog_pad_tap;
  logic       global_pullup_disable;
  logic [7:0] pin_output_bit;
  logic [7:0] pin_direction_bit;

  modport port (
    input  pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    input  value_override_en, value_override_val, toggle_override_en,
    input  input_en_override_en, input_en_override_val,
    output alt_digital_input_tap, analog_pad_tap, global_pullup_disable,
    output pin_output_bit, pin_direction_bit
  );

  modport periph (
    output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    output value_override_en, value_override_val, toggle_override_en,
    output input_en_override_en, input_en_override_val,
    input  alt_digital_input_tap, analog_pad_tap, global_pullup_disable,
    input  pin_output_bit, pin_direction_bit
  );
endinterface
`default_nettype wire

// [ppo_port.sv]
// Purpose: Port B pin logic with alternate-function overrides and an APB register file.
// Assumes: Pad drivers, pull-ups and input enables act on the registered pad controls.
// Notes:   Pad controls lag the override inputs by one pclk cycle.
//
// Overview of operation
// [R1] Pull-up override enable selects pull-up override value.
// [R2] Otherwise pull-up on when pattern equals 010.
// [R3] Direction override enable selects driver from override.
// [R4] Otherwise driver enable follows direction bit.
// [R5] Value override drives pin when driver on.
// [R6] Otherwise pin level follows output bit.
// [R7] Toggle override inverts stored output bit.
// [R8] Input-enable override sets digital input enable.
// [R9] Otherwise sleep state clamps digital input.
// [R10] Alternate input tapped before synchronizer; receivers resynchronise.
// [R11] Analog tap routed straight from the pad.
// [R12] Peripherals generate their own override signals.
// [R13] Strobes per port, globals shared, overrides per pin.
// [R14] Pull-up disable bit four kills the pull-ups of all other pins; SPI master pins 3..0 pull up when it and the output bit are set.
// [R15] Bit 7 carries timer 0 compare A.
// [R16] Bit 7 alternatively carries timer 1 compare C.
// [R17] Bit 7 also pin-change 7 and RTS.
// [R18] Bits 6..4 analog channels 13..11, timer outputs.
// [R19] Bits 3..0 SPI, programming and pin-change sources.
// [R20] Enabled external interrupt pins escape sleep clamping.
// [R21] Absent overrides read as disabled and zero.
// [R22] Value override wins level; toggle still updates bit.
//
// Added by the designer: the register offsets and register access over APB.
`default_nettype none
module ppo_port (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller state
  input  wire logic        sleep,
  input  wire logic [7:0]  ext_int_en,
  // Pad side
  input  wire logic [7:0]  pad_in,
  input  wire logic [7:0]  pad_analog,
  output logic      [7:0]  pad_out,
  output logic      [7:0]  pad_oe,
  output logic      [7:0]  pad_pullup,
  output logic      [7:0]  pad_input_en,
  // Override carrier
  ppo_if.port              ovr
);

  logic [7:0]  out_reg;
  logic [7:0]  out_next;
  logic [7:0]  dir_reg;
  logic [7:0]  dir_next;
  logic        pud_reg;
  logic [7:0]  pin_s1_reg;
  logic [7:0]  pin_s2_reg;
  logic [7:0]  pad_out_reg;
  logic [7:0]  pad_oe_reg;
  logic [7:0]  pad_pullup_reg;
  logic [7:0]  pad_input_en_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        hit_next;

  logic [7:0]  pu_w;
  logic [7:0]  oe_w;
  logic [7:0]  val_w;
  logic [7:0]  die_w;
  logic [7:0]  digital_in_w;

  // Bus phase and address decode.
  wire         setup_w    = psel & ~penable;
  wire         access_w   = psel & penable & pready_reg;
  wire         hi_zero_w  = (paddr[31:ppo_pkg::ADDR_LSB_W] == 24'h000000);
  wire  [7:0]  ofs_w      = paddr[ppo_pkg::ADDR_LSB_W-1:0];
  wire         sel_ctrl_w = hi_zero_w & (ofs_w == ppo_pkg::CTRL_OFS);
  wire         sel_out_w  = hi_zero_w & (ofs_w == ppo_pkg::OUT_OFS);
  wire         sel_dir_w  = hi_zero_w & (ofs_w == ppo_pkg::DIR_OFS);
  wire         sel_pin_w  = hi_zero_w & (ofs_w == ppo_pkg::PIN_OFS);
  wire         sel_pad_w  = hi_zero_w & (ofs_w == ppo_pkg::PADST_OFS);
  wire         wr_w       = access_w & pwrite & ~pslverr_reg;
  wire         wr_ctrl_w  = wr_w & sel_ctrl_w;
  wire         wr_out_w   = wr_w & sel_out_w;
  wire         wr_dir_w   = wr_w & sel_dir_w;

  // Read data is latched in the setup cycle so that prdata comes from a flop.
  always_comb begin
    rdata_next = 32'h00000000;
    hit_next   = 1'b1;
    if (sel_ctrl_w) begin
      rdata_next[ppo_pkg::PUD_BIT] = pud_reg;
    end else if (sel_out_w) begin
      rdata_next[7:0] = out_reg;
    end else if (sel_dir_w) begin
      rdata_next[7:0] = dir_reg;
    end else if (sel_pin_w) begin
      rdata_next[7:0] = pin_s2_reg;
    end else if (sel_pad_w) begin
      rdata_next[31:0] = {pad_input_en_reg, pad_pullup_reg, pad_oe_reg, pad_out_reg};
    end else begin
      hit_next = 1'b0;
    end
  end

  // Software write lands first, then any toggle request flips the stored bit.
  always_comb begin
    out_next = out_reg;
    if (wr_out_w) begin
      out_next = pwdata[7:0];
    end
    out_next = out_next ^ ovr.toggle_override_en; // [R7] [R22]
  end

  assign dir_next = wr_dir_w ? pwdata[7:0] : dir_reg;

  // Per-pin override selection; absent overrides arrive tied low from the peripheral end.
  for (genvar i = 0; i < ppo_pkg::NPINS; i++) begin : g_pin
    assign pu_w[i]  = ovr.pullup_override_en[i] ? ovr.pullup_override_val[i] : // [R1]
                      ({dir_reg[i], out_reg[i], pud_reg} == ppo_pkg::PU_PATTERN); // [R2] [R14]
    assign oe_w[i]  = ovr.dir_override_en[i] ? ovr.dir_override_val[i] : dir_reg[i]; // [R3] [R4]
    assign val_w[i] = ovr.value_override_en[i] ? ovr.value_override_val[i] : out_reg[i]; // [R5] [R6] [R22]
    // An enabled external interrupt keeps the pin readable through sleep.
    assign die_w[i] = ovr.input_en_override_en[i] ? ovr.input_en_override_val[i] : // [R8]
                      (~sleep | ext_int_en[i]); // [R9] [R20]
  end

  // The clamp sits ahead of the input buffer, so a disabled input reads low.
  assign digital_in_w = pad_in & die_w;

  // Alternate functions see the raw level; they must synchronise it themselves.
  assign ovr.alt_digital_input_tap = digital_in_w; // [R10]
  assign ovr.analog_pad_tap        = pad_analog; // [R11]
  // The shared controls go to every pin of every port from one place.
  assign ovr.global_pullup_disable = pud_reg; // [R13]
  assign ovr.pin_output_bit        = out_reg;
  assign ovr.pin_direction_bit     = dir_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= ppo_pkg::OUT_RST;
      dir_reg <= ppo_pkg::DIR_RST;
      pud_reg <= ppo_pkg::CTRL_RST[ppo_pkg::PUD_BIT];
    end else begin
      out_reg <= out_next;
      dir_reg <= dir_next;
      if (wr_ctrl_w) begin
        pud_reg <= pwdata[ppo_pkg::PUD_BIT]; // [R14]
      end
    end
  end

  // Port pin read path: two flops before software sees the level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= digital_in_w;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // A disabled driver also parks the output level low to keep the pad quiet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_reg      <= 8'h00;
      pad_oe_reg       <= 8'h00;
      pad_pullup_reg   <= 8'h00;
      pad_input_en_reg <= 8'h00;
    end else begin
      pad_out_reg      <= oe_w & val_w; // [R5] [R6]
      pad_oe_reg       <= oe_w; // [R3] [R4]
      pad_pullup_reg   <= pu_w; // [R1] [R2]
      pad_input_en_reg <= die_w; // [R8] [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_w;
      if (setup_w) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rdata_next;
        pslverr_reg <= ~hit_next | (pwrite & (sel_pin_w | sel_pad_w));
      end else if (access_w) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign pad_out      = pad_out_reg;
  assign pad_oe       = pad_oe_reg;
  assign pad_pullup   = pad_pullup_reg;
  assign pad_input_en = pad_input_en_reg;

endmodule
`default_nettype wire

// [ppo_periph.sv]
// Purpose: Peripheral end that turns port B alternate functions into pin overrides.
// Assumes: Peripheral enables and outputs are synchronous to pclk.
// Notes:   Overrides are registered, so they reach the carrier one cycle after the inputs and the pads two.
`default_nettype none
module ppo_periph (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Timer outputs and their enables
  input  wire logic       timer0_compare_a_out,
  input  wire logic       timer0_compare_a_en,
  input  wire logic       timer1_compare_c_out,
  input  wire logic       timer1_compare_c_en,
  input  wire logic       timer1_compare_b_out,
  input  wire logic       timer1_compare_b_en,
  input  wire logic       timer1_compare_a_out,
  input  wire logic       timer1_compare_a_en,
  input  wire logic       timer4_compare_b_out,
  input  wire logic       timer4_compare_b_en,
  // UART flow control
  input  wire logic       uart_rts_out,
  input  wire logic       uart_rts_en,
  // SPI and serial programming
  input  wire logic       spi_enable,
  input  wire logic       spi_master,
  input  wire logic       spi_mosi_out,
  input  wire logic       spi_miso_out,
  input  wire logic       spi_sck_out,
  input  wire logic       prog_mode,
  input  wire logic       prog_data_out,
  // Pin-change interrupt control
  input  wire logic [7:0] pin_change_mask,
  input  wire logic       pin_change_enable,
  // Synchronised inputs, and the unsynchronised analog taps, back to the peripherals
  output logic      [7:0] pin_change_src,
  output logic            spi_miso_in,
  output logic            spi_mosi_in,
  output logic            spi_sck_in,
  output logic            spi_ss_in,
  output logic            prog_data_in,
  output logic      [7:0] analog_channel_in,
  // Override carrier
  ppo_if.periph           ovr
);

  logic [7:0] tap_s1_reg;
  logic [7:0] tap_s2_reg;
  logic [7:0] pullup_override_en_reg;
  logic [7:0] pullup_override_val_reg;
  logic [7:0] dir_override_en_reg;
  logic [7:0] dir_override_val_reg;
  logic [7:0] value_override_en_reg;
  logic [7:0] value_override_val_reg;
  logic [7:0] input_en_override_en_reg;
  logic [7:0] pullup_override_en_w;
  logic [7:0] pullup_override_val_w;
  logic [7:0] dir_override_en_w;
  logic [7:0] dir_override_val_w;
  logic [7:0] value_override_en_w;
  logic [7:0] value_override_val_w;

  wire spi_mst_w = spi_enable & spi_master;
  wire pud_w     = ovr.global_pullup_disable;

  // Only driven when the pin direction bit is one; the port keeps that gate.
  wire b7_en_w   = timer0_compare_a_en | timer1_compare_c_en | uart_rts_en; // [R15] [R16] [R17]
  wire b7_val_w  = timer0_compare_a_en ? timer0_compare_a_out : // [R15]
                   timer1_compare_c_en ? timer1_compare_c_out : uart_rts_out; // [R16] [R17]
  // Timer 4 compare B drives bit 6 true and bit 5 complemented.
  wire b6_en_w   = timer1_compare_b_en | timer4_compare_b_en; // [R18]
  wire b6_val_w  = timer1_compare_b_en ? timer1_compare_b_out : timer4_compare_b_out;
  wire b5_en_w   = timer1_compare_a_en | timer4_compare_b_en; // [R18]
  wire b5_val_w  = timer1_compare_a_en ? timer1_compare_a_out : ~timer4_compare_b_out;

  // The SPI pins share one enable, pin 0 aside for value, with prog_mode added at pin 3 for direction and value; pins without an override stay at zero.
  assign pullup_override_en_w = {4'h0, {4{spi_mst_w}}}; // [R12] [R19] [R21]
  assign pullup_override_val_w = {4'h0, ovr.pin_output_bit[3:0] & {4{pud_w}}}; // [R19]
  assign dir_override_en_w = {4'h0, prog_mode | spi_mst_w, {3{spi_mst_w}}}; // [R19]
  assign dir_override_val_w = {4'h0, prog_mode, 3'b000}; // [R19]
  assign value_override_en_w = {b7_en_w, b6_en_w, b5_en_w, 1'b0, prog_mode | spi_mst_w, {2{spi_mst_w}}, 1'b0}; // [R21]
  assign value_override_val_w = {b7_val_w, b6_val_w, b5_val_w, 1'b0, // [R15] [R18]
                   prog_mode ? prog_data_out : spi_miso_out, spi_mosi_out, spi_sck_out, 1'b0}; // [R19]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_override_en_reg  <= 8'h00;
      pullup_override_val_reg  <= 8'h00;
      dir_override_en_reg  <= 8'h00;
      dir_override_val_reg  <= 8'h00;
      value_override_en_reg  <= 8'h00;
      value_override_val_reg  <= 8'h00;
      input_en_override_en_reg <= 8'h00;
    end else begin
      pullup_override_en_reg  <= pullup_override_en_w;
      pullup_override_val_reg  <= pullup_override_val_w;
      dir_override_en_reg  <= dir_override_en_w;
      dir_override_val_reg  <= dir_override_val_w;
      value_override_en_reg  <= value_override_en_w;
      value_override_val_reg  <= value_override_val_w;
      input_en_override_en_reg <= pin_change_mask & {8{pin_change_enable}}; // [R17] [R19]
    end
  end

  // The tap is asynchronous to pclk, so it is resynchronised here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_s1_reg <= 8'h00;
      tap_s2_reg <= 8'h00;
    end else begin
      tap_s1_reg <= ovr.alt_digital_input_tap; // [R10]
      tap_s2_reg <= tap_s1_reg;
    end
  end

  assign ovr.pullup_override_en    = pullup_override_en_reg; // [R12]
  assign ovr.pullup_override_val   = pullup_override_val_reg;
  assign ovr.dir_override_en       = dir_override_en_reg;
  assign ovr.dir_override_val      = dir_override_val_reg;
  assign ovr.value_override_en     = value_override_en_reg;
  assign ovr.value_override_val    = value_override_val_reg;
  assign ovr.toggle_override_en    = 8'h00; // [R21]
  assign ovr.input_en_override_en  = input_en_override_en_reg;
  assign ovr.input_en_override_val = 8'hFF;

  assign pin_change_src    = tap_s2_reg; // [R17] [R19]
  assign spi_ss_in         = tap_s2_reg[ppo_pkg::PIN_SS];
  assign spi_sck_in        = tap_s2_reg[ppo_pkg::PIN_SCK];
  assign spi_mosi_in       = tap_s2_reg[ppo_pkg::PIN_MOSI];
  assign prog_data_in      = tap_s2_reg[ppo_pkg::PIN_MOSI];
  assign spi_miso_in       = tap_s2_reg[ppo_pkg::PIN_MISO];
  // Analog levels are passed through untouched; bits 6..4 feed channels 13..11.
  assign analog_channel_in = ovr.analog_pad_tap; // [R11] [R18]

endmodule
`default_nettype wire

// [ppo_monitor.sv]
// Purpose: Concurrent checks on the override carrier and the registered pad controls.
// Assumes: One pclk domain; pad controls follow their cause one edge later.
// Notes:   Checks except a_alt_tap and a_analog_pass wait one edge after reset release so that no reset-time value is compared.
`default_nettype none
module ppo_monitor (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Override carrier
  input wire logic [7:0] pullup_override_en,
  input wire logic [7:0] pullup_override_val,
  input wire logic [7:0] dir_override_en,
  input wire logic [7:0] dir_override_val,
  input wire logic [7:0] value_override_en,
  input wire logic [7:0] value_override_val,
  input wire logic [7:0] input_en_override_en,
  input wire logic [7:0] input_en_override_val,
  input wire logic [7:0] alt_digital_input_tap,
  input wire logic [7:0] analog_pad_tap,
  input wire logic       global_pullup_disable,
  input wire logic [7:0] pin_output_bit,
  input wire logic [7:0] pin_direction_bit,
  // Pad side and controller state
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_analog,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] pad_input_en,
  input wire logic       sleep,
  input wire logic [7:0] ext_int_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       up;
  logic [7:0] pu_w, oe_w, out_w, ie_w;
  assign pu_w  = ~pin_direction_bit & pin_output_bit & ~{8{global_pullup_disable}};
  assign oe_w  = (dir_override_en & dir_override_val) | (~dir_override_en & pin_direction_bit);
  assign out_w = oe_w & ((value_override_en & value_override_val) | (~value_override_en & pin_output_bit));
  assign ie_w  = (input_en_override_en & input_en_override_val) | (~input_en_override_en & ({8{~sleep}} | ext_int_en));
  // The edge that releases reset still runs the reset branch, so checks gated by up start one edge later.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up <= 1'b0;
    else          up <= 1'b1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_clamped;
    up && sleep && (ext_int_en == 8'h00) && (input_en_override_en == 8'h00);
  endsequence
  a_pullup_ovr: assert property (up && pullup_override_en != 8'h00 |=>
    ((pad_pullup ^ $past(pullup_override_val)) & $past(pullup_override_en)) == 8'h00) else $error("pull-up override lost");
  a_pullup_pattern: assert property (up && pullup_override_en != 8'hFF |=>
    ((pad_pullup ^ $past(pu_w)) & ~$past(pullup_override_en)) == 8'h00) else $error("pull-up pattern wrong");
  a_pud_kills: assert property (up && global_pullup_disable && pullup_override_en == 8'h00 |=>
    pad_pullup == 8'h00) else $error("pull-up on while disabled");
  a_driver_enable: assert property (up |=> pad_oe == $past(oe_w)) else $error("driver enable wrong");
  a_value_select: assert property (up |=> pad_out == $past(out_w)) else $error("pin level wrong");
  a_input_enable: assert property (up |=> pad_input_en == $past(ie_w)) else $error("input enable wrong");
  a_sleep_clamp: assert property (s_clamped [*2] |-> pad_input_en == 8'h00) else $error("input not clamped");
  // The tap is clamped by the live input enable, one cycle ahead of the registered pad control.
  a_alt_tap: assert property (alt_digital_input_tap == (pad_in & ie_w)) else $error("digital tap wrong");
  a_analog_pass: assert property (analog_pad_tap == pad_analog) else $error("analog tap wrong");
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the pin end and the peripheral end joined by the carrier.
// Assumes: The bench waits for pready rather than counting on a one-cycle answer.
// Notes:   Peripheral inputs reach the pads two edges later, so override checks wait four.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep, pce, err;
  logic [31:0] paddr, pwdata, prdata, seed, rd, w;
  logic [7:0]  ext_int_en, pad_in, pad_analog, pad_out, pad_oe, pad_pullup, pad_input_en, pcm, pcs, an_in, d, o;
  logic [18:0] pi;
  logic [4:0]  sin;
  logic [7:0]  ofs [3];
  int          errors, tests_run;
  ppo_if i_ppo_if ();
  ppo_port i_ppo_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .ext_int_en(ext_int_en), .pad_in(pad_in), .pad_analog(pad_analog), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_input_en(pad_input_en), .ovr(i_ppo_if));
  ppo_periph i_ppo_periph (.pclk(pclk), .presetn(presetn), .timer0_compare_a_out(pi[0]),
    .timer0_compare_a_en(pi[1]), .timer1_compare_c_out(pi[2]), .timer1_compare_c_en(pi[3]),
    .timer1_compare_b_out(pi[4]), .timer1_compare_b_en(pi[5]), .timer1_compare_a_out(pi[6]),
    .timer1_compare_a_en(pi[7]), .timer4_compare_b_out(pi[8]), .timer4_compare_b_en(pi[9]),
    .uart_rts_out(pi[10]), .uart_rts_en(pi[11]), .spi_enable(pi[12]), .spi_master(pi[13]),
    .spi_mosi_out(pi[14]), .spi_miso_out(pi[15]), .spi_sck_out(pi[16]), .prog_mode(pi[17]),
    .prog_data_out(pi[18]), .pin_change_mask(pcm), .pin_change_enable(pce), .pin_change_src(pcs),
    .spi_miso_in(sin[3]), .spi_mosi_in(sin[2]), .spi_sck_in(sin[1]), .spi_ss_in(sin[0]),
    .prog_data_in(sin[4]), .analog_channel_in(an_in),
    .ovr(i_ppo_if));
  ppo_monitor i_ppo_monitor (.pclk(pclk), .presetn(presetn),
    .pullup_override_en(i_ppo_if.pullup_override_en), .pullup_override_val(i_ppo_if.pullup_override_val),
    .dir_override_en(i_ppo_if.dir_override_en), .dir_override_val(i_ppo_if.dir_override_val),
    .value_override_en(i_ppo_if.value_override_en), .value_override_val(i_ppo_if.value_override_val),
    .input_en_override_en(i_ppo_if.input_en_override_en), .input_en_override_val(i_ppo_if.input_en_override_val),
    .alt_digital_input_tap(i_ppo_if.alt_digital_input_tap), .analog_pad_tap(i_ppo_if.analog_pad_tap),
    .global_pullup_disable(i_ppo_if.global_pullup_disable), .pin_output_bit(i_ppo_if.pin_output_bit),
    .pin_direction_bit(i_ppo_if.pin_direction_bit), .pad_in(pad_in), .pad_analog(pad_analog),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_input_en(pad_input_en),
    .sleep(sleep), .ext_int_en(ext_int_en));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected pad status word {input enable, pull-up, driver enable, level} with no override active.
  function automatic logic [31:0] pad_exp(logic [7:0] dv, logic [7:0] ov, logic p, logic s, logic [7:0] e);
    return {({8{~s}} | e), (~dv & ov & ~{8{p}}), dv, (dv & ov)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {24'h000000, a};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: only the watchdog may end a wait for pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ovr_chk(input logic [18:0] p, input int pin, input logic lvl);
    pi <= p;
    repeat (4) @(posedge pclk);
    chk("pad_out pin", {31'h0, lvl}, {31'h0, pad_out[pin]});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report();
  end
  initial begin
    seed = 32'h27E6B81B;
    ofs  = '{ppo_pkg::CTRL_OFS, ppo_pkg::OUT_OFS, ppo_pkg::DIR_OFS};
    {presetn, psel, penable, pwrite, sleep, pce} = '0;
    {paddr, pwdata, ext_int_en, pad_in, pad_analog, pcm, pi} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", 32'h0, rd);
      w = rnd();
      apb(1'b1, ofs[i], w);
      apb(1'b0, ofs[i], 32'h0);
      chk("read back", (i == 0) ? (w & (32'h1 << ppo_pkg::PUD_BIT)) : {24'h0, w[7:0]}, rd);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, ppo_pkg::PIN_OFS, w);
    chk("read-only error", 32'h1, {31'h0, err});
    $display("done: registers");
    for (int k = 0; k < 32; k++) begin
      w = rnd();
      d = (k < 2) ? 8'h00 : w[7:0];
      o = (k < 2) ? 8'hFF : w[15:8];
      sleep      <= w[17];
      ext_int_en <= w[31:24] & {8{w[18]}};
      pad_analog <= w[23:16];
      apb(1'b1, ppo_pkg::CTRL_OFS, {27'h0, w[16] & (k != 1), 4'h0});
      apb(1'b1, ppo_pkg::OUT_OFS, {24'h0, o});
      apb(1'b1, ppo_pkg::DIR_OFS, {24'h0, d});
      apb(1'b0, ppo_pkg::PADST_OFS, 32'h0);
      chk("pad status", pad_exp(d, o, w[16] & (k != 1), w[17], w[31:24] & {8{w[18]}}), rd);
      chk("analog channel", {24'h0, w[23:16]}, {24'h0, an_in});
    end
    $display("done: random pad control");
    sleep <= 1'b0;
    apb(1'b1, ppo_pkg::DIR_OFS, 32'hFF);
    apb(1'b1, ppo_pkg::OUT_OFS, 32'h00);
    apb(1'b1, ppo_pkg::CTRL_OFS, 32'h00);
    ovr_chk(19'h00003, 7, 1'b1);
    ovr_chk(19'h0000C, 7, 1'b1);
    ovr_chk(19'h00C00, 7, 1'b1);
    ovr_chk(19'h00030, 6, 1'b1);
    ovr_chk(19'h000C0, 5, 1'b1);
    ovr_chk(19'h00300, 6, 1'b1);
    ovr_chk(19'h00200, 5, 1'b1);
    ovr_chk(19'h60000, 3, 1'b1);
    pi <= 19'h03000;
    repeat (4) @(posedge pclk);
    chk("spi master input pin", 32'h0, {31'h0, pad_oe[ppo_pkg::PIN_MISO]});
    apb(1'b1, ppo_pkg::DIR_OFS, 32'h7F);
    ovr_chk(19'h00003, 7, 1'b0);
    chk("pin 7 driver", 32'h0, {31'h0, pad_oe[7]});
    $display("done: alternate outputs");
    pi         <= 19'h0;
    sleep      <= 1'b1;
    ext_int_en <= 8'h00;
    pcm        <= 8'h10;
    pce        <= 1'b1;
    pad_in     <= 8'hFF;
    repeat (6) @(posedge pclk);
    chk("input enable in sleep", 32'h10, {24'h0, pad_input_en});
    chk("pin change source", 32'h10, {24'h0, pcs});
    ext_int_en <= 8'h01;
    repeat (6) @(posedge pclk);
    chk("external pin in sleep", 32'h11, {24'h0, pad_input_en});
    // Only pin 0 of the SPI group is enabled, so only the select input reads high.
    chk("spi inputs", 32'h1, {27'h0, sin});
    $display("done: sleep and pin change");
    final_report();
  end
endmodule
`default_nettype wire
